// ==== logic/antenna_band_pkg.sv ====
// Constants and carrier types for the antenna band line controller.
// Assumes a single 20 MHz core clock and an antenna that answers band code 0000.
package antenna_band_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and serial timing.
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned HZ_PER_KHZ = 1000;
    localparam int unsigned CYCLES_PER_MS = CLK_HZ / HZ_PER_KHZ;
    localparam int unsigned BAUD = 300;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrogation timing, in milliseconds.
    localparam int unsigned MS_W = 13;
    localparam int unsigned HOLD_MIN_MS = 230;
    localparam int unsigned HOLD_MAX_MS = 366;
    localparam int unsigned HOLD_MS = 298;
    localparam int unsigned ACK_SETTLE_MS = 2;
    localparam int unsigned RX_TIMEOUT_MS = 4000;

    ////////////////////////////////////////////////////////////////////////////////
    // Band codes; bit 0 of a code is line bit-1.
    localparam logic [3:0] CODE_POLL = 4'h0;
    localparam logic [3:0] CODE_BAND01 = 4'h1;
    localparam logic [3:0] LINES_ALL = 4'hF;
    localparam logic [3:0] LINES_NONE = 4'h0;
    localparam logic [2:0] ACK_ALL_HIGH = 3'h7;
    localparam logic [3:0] LEGACY_OFFSET = 4'h2;
    localparam logic [3:0] LEGACY_MIN = 4'h3;
    localparam logic [3:0] LEGACY_MAX = 4'h9;
    localparam logic [3:0] OLDER_MAX = 4'h7;
    localparam logic [3:0] MAX_BANDS = 4'hF;

    ////////////////////////////////////////////////////////////////////////////////
    // Characters of the identification text.
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_DASH = 8'h2D;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_PRINT_HI = 8'h7E;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic busy;
        logic done;
        logic known;
        logic unknown;
        logic [3:0] band_count;
    } id_status_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } line_drive_t;

endpackage

// ==== logic/serial_rx_8n1.sv ====
// Eight data bits, no parity, one stop bit receiver, LSB first.
// Assumes rx is already synchronised to core_clk and idles high.
`timescale 1ns/1ps
module serial_rx_8n1 #(
    parameter int unsigned BIT_CYCLES = antenna_band_pkg::BIT_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Serial line
    input wire logic rx_en,
    input wire logic rx,
    // Received characters
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic frame_err
);

    localparam int unsigned CW = $clog2(BIT_CYCLES) + 1;
    localparam logic [CW-1:0] HALF_BIT = CW'(BIT_CYCLES / 2 - 1);
    localparam logic [CW-1:0] FULL_BIT = CW'(BIT_CYCLES - 1);

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

    rx_state_t state_q;
    logic [CW-1:0] cnt_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic armed_q;

    ////////////////////////////////////////////////////////////////////////////////
    // The antenna holds the line low before its text, so a start bit is only
    // believed after the line has been seen idle high once.
    always_ff @(posedge core_clk) begin
        if (!rst_n || !rx_en) begin
            armed_q <= 1'b0;
        end else if (rx) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || !rx_en) begin
            state_q <= RX_IDLE;
            cnt_q <= '0;
            bit_q <= 3'h0;
            shift_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + CW'(1);
            unique case (state_q)
                RX_IDLE: begin
                    cnt_q <= '0;
                    if (armed_q && !rx) begin
                        state_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (cnt_q == HALF_BIT) begin
                        cnt_q <= '0;
                        bit_q <= 3'h0;
                        state_q <= rx ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (cnt_q == FULL_BIT) begin
                        cnt_q <= '0;
                        shift_q <= {rx, shift_q[7:1]};
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            state_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (cnt_q == FULL_BIT) begin
                        state_q <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            byte_valid <= 1'b0;
            frame_err <= 1'b0;
            byte_data <= 8'h00;
        end else begin
            byte_valid <= 1'b0;
            frame_err <= 1'b0;
            if (rx_en && state_q == RX_STOP && cnt_q == FULL_BIT) begin
                byte_valid <= rx;
                frame_err <= !rx;
                byte_data <= shift_q;
            end
        end
    end

endmodule // serial_rx_8n1

// ==== logic/antenna_band_interrogation_ctrl.sv ====
// Band line controller: drives band codes and interrogates the antenna's identity module.
// Assumes band lines resolved outside from out/oe, and query_start from core_clk logic.
`timescale 1ns/1ps

// Summary of operation
// - In normal operation all four band lines are driven as outputs.
// - A query starts by driving all four lines low together, code 0000.
// - Code 0000 is held at least 230 ms.
// - Code 0000 is held no longer than 366 ms.
// - Code 0000 is released 298 ms after it was asserted.
// - At release, bit-1 becomes serial input and bits 2 to 4 become inputs.
// - Bits 2 to 4 are sampled after release; any low means unknown antenna.
// - The received text is parsed; an illegitimate text means unknown antenna.
// - Bit-1 receiver takes 300 baud, eight data bits, no parity, one stop.
// - After the text, all lines become outputs again and drive band 01.
// - Legacy antenna: line band equals its labelled band minus two, bands 03 to 09.
// - An older processor's band equals current antenna band plus two, 01 to 07.
// - Codes are binary, bit-1 least significant; bands 01 to 15.
module antenna_band_interrogation_ctrl #(
    parameter int unsigned CYCLES_PER_MS = antenna_band_pkg::CYCLES_PER_MS,
    parameter int unsigned BIT_CYCLES = antenna_band_pkg::BIT_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Band select lines
    input wire logic [3:0] band_select_line_in,
    output antenna_band_pkg::line_drive_t band_select_line,
    // Band selection
    input wire logic band_load,
    input wire logic [3:0] band_sel,
    input wire logic legacy_antenna,
    output logic [3:0] older_proc_band,
    // Identification
    input wire logic query_start,
    output antenna_band_pkg::id_status_t id_status
);

    localparam int unsigned DW = $clog2(CYCLES_PER_MS);
    localparam int unsigned MS_W = antenna_band_pkg::MS_W;

    typedef enum logic [1:0] {ST_NORMAL, ST_HOLD, ST_ACK, ST_RECV} ctrl_state_t;
    typedef enum logic [3:0] {
        P_MODEL_FIRST, P_MODEL, P_SPACE, P_LO_FIRST, P_LO, P_HI_FIRST, P_HI, P_LF,
        P_DONE, P_BAD
    } parse_state_t;

    ctrl_state_t state_q, state_d;
    parse_state_t parse_q;
    logic [3:0] sync1_q, sync2_q;
    logic [DW-1:0] div_q;
    logic [MS_W-1:0] ms_q;
    logic ms_tick;
    logic [3:0] drive_q, drive_d;
    logic [3:0] count_q;
    logic rx_valid, rx_err;
    logic [7:0] rx_data;
    logic ack_ok, finish, parse_ok, is_digit, is_print;

    ////////////////////////////////////////////////////////////////////////////////
    // Line inputs come from the antenna, so they are synchronised first.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= band_select_line_in;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Millisecond time base, restarted on every state change so each interval
    // is a whole number of milliseconds from its own start.
    assign ms_tick = (div_q == DW'(CYCLES_PER_MS - 1));

    always_ff @(posedge core_clk) begin
        if (!rst_n || state_d != state_q) begin
            div_q <= '0;
            ms_q <= '0;
        end else if (ms_tick) begin
            div_q <= '0;
            ms_q <= ms_q + MS_W'(1);
        end else begin
            div_q <= div_q + DW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    assign ack_ok = (sync2_q[3:1] == antenna_band_pkg::ACK_ALL_HIGH);
    assign parse_ok = (parse_q == P_DONE) && (count_q != 4'h0);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_NORMAL: begin
                if (query_start) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (ms_tick && ms_q == MS_W'(antenna_band_pkg::HOLD_MS - 1)) begin
                    state_d = ST_ACK;
                end
            end
            ST_ACK: begin
                if (ms_tick && ms_q == MS_W'(antenna_band_pkg::ACK_SETTLE_MS - 1)) begin
                    state_d = ack_ok ? ST_RECV : ST_NORMAL;
                end
            end
            ST_RECV: begin
                if (parse_q == P_DONE || parse_q == P_BAD) begin
                    state_d = ST_NORMAL;
                end else if (ms_tick && ms_q == MS_W'(antenna_band_pkg::RX_TIMEOUT_MS - 1)) begin
                    state_d = ST_NORMAL;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= ST_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    assign finish = (state_q == ST_ACK || state_q == ST_RECV) && state_d == ST_NORMAL;

    ////////////////////////////////////////////////////////////////////////////////
    // Band code. Loads outside normal mode are dropped, as are codes that
    // would land on the reserved poll code.
    always_comb begin
        drive_d = drive_q;
        if (finish) begin
            drive_d = antenna_band_pkg::CODE_BAND01;
        end else if (state_q == ST_NORMAL && band_load) begin
            if (legacy_antenna) begin
                if (band_sel >= antenna_band_pkg::LEGACY_MIN
                        && band_sel <= antenna_band_pkg::LEGACY_MAX) begin
                    drive_d = band_sel - antenna_band_pkg::LEGACY_OFFSET;
                end
            end else if (band_sel != antenna_band_pkg::CODE_POLL) begin
                drive_d = band_sel;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            drive_q <= antenna_band_pkg::CODE_BAND01;
            band_select_line.out <= antenna_band_pkg::CODE_BAND01;
            band_select_line.oe <= antenna_band_pkg::LINES_ALL;
        end else begin
            drive_q <= drive_d;
            if (state_d == ST_HOLD) begin
                band_select_line.out <= antenna_band_pkg::CODE_POLL;
                band_select_line.oe <= antenna_band_pkg::LINES_ALL;
            end else if (state_d == ST_NORMAL) begin
                band_select_line.out <= drive_d;
                band_select_line.oe <= antenna_band_pkg::LINES_ALL;
            end else begin
                band_select_line.out <= antenna_band_pkg::CODE_POLL;
                band_select_line.oe <= antenna_band_pkg::LINES_NONE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            older_proc_band <= 4'h0;
        end else if (drive_q != 4'h0 && drive_q <= antenna_band_pkg::OLDER_MAX) begin
            older_proc_band <= drive_q + antenna_band_pkg::LEGACY_OFFSET;
        end else begin
            older_proc_band <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial receiver on bit-1, live from the moment the lines are released.
    serial_rx_8n1 #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_rx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .rx_en(state_q == ST_ACK || state_q == ST_RECV),
        .rx(sync2_q[0]),
        .byte_valid(rx_valid),
        .byte_data(rx_data),
        .frame_err(rx_err)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Identification text parser. Range order is not checked: only shape.
    assign is_digit = rx_data >= antenna_band_pkg::CH_ZERO && rx_data <= antenna_band_pkg::CH_NINE;
    assign is_print = rx_data >= antenna_band_pkg::CH_SPACE
        && rx_data <= antenna_band_pkg::CH_PRINT_HI && rx_data != antenna_band_pkg::CH_COMMA;

    always_ff @(posedge core_clk) begin
        if (!rst_n || state_q == ST_HOLD) begin
            parse_q <= P_MODEL_FIRST;
            count_q <= 4'h0;
        end else if (rx_err) begin
            parse_q <= P_BAD;
        end else if (rx_valid) begin
            unique case (parse_q)
                P_MODEL_FIRST: begin
                    parse_q <= (is_print && rx_data != antenna_band_pkg::CH_SPACE)
                        ? P_MODEL : P_BAD;
                end
                P_MODEL: begin
                    if (rx_data == antenna_band_pkg::CH_COMMA) begin
                        parse_q <= P_SPACE;
                    end else if (!is_print) begin
                        parse_q <= P_BAD;
                    end
                end
                P_SPACE: begin
                    parse_q <= (rx_data == antenna_band_pkg::CH_SPACE) ? P_LO_FIRST : P_BAD;
                end
                P_LO_FIRST: begin
                    parse_q <= is_digit ? P_LO : P_BAD;
                end
                P_LO: begin
                    if (rx_data == antenna_band_pkg::CH_DASH) begin
                        parse_q <= P_HI_FIRST;
                    end else if (!is_digit) begin
                        parse_q <= P_BAD;
                    end
                end
                P_HI_FIRST: begin
                    parse_q <= is_digit ? P_HI : P_BAD;
                end
                P_HI: begin
                    if (rx_data == antenna_band_pkg::CH_COMMA
                            && count_q != antenna_band_pkg::MAX_BANDS) begin
                        count_q <= count_q + 4'h1;
                        parse_q <= P_SPACE;
                    end else if (rx_data == antenna_band_pkg::CH_CR) begin
                        count_q <= count_q + 4'h1;
                        parse_q <= P_LF;
                    end else if (!is_digit) begin
                        parse_q <= P_BAD;
                    end
                end
                P_LF: begin
                    parse_q <= (rx_data == antenna_band_pkg::CH_LF) ? P_DONE : P_BAD;
                end
                P_DONE, P_BAD: begin
                    parse_q <= parse_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            id_status <= '0;
        end else begin
            id_status.busy <= (state_d != ST_NORMAL);
            id_status.done <= finish;
            if (state_q == ST_NORMAL && query_start) begin
                id_status.known <= 1'b0;
                id_status.unknown <= 1'b0;
                id_status.band_count <= 4'h0;
            end else if (finish) begin
                id_status.known <= (state_q == ST_RECV) && parse_ok;
                id_status.unknown <= !((state_q == ST_RECV) && parse_ok);
                id_status.band_count <= parse_ok ? count_q : 4'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks. The hold counter exists only to measure code 0000 in cycles.
    localparam int unsigned HOLD_MIN_CYC = antenna_band_pkg::HOLD_MIN_MS * CYCLES_PER_MS;
    localparam int unsigned HOLD_MAX_CYC = antenna_band_pkg::HOLD_MAX_MS * CYCLES_PER_MS;
    localparam int unsigned HOLD_CYC = antenna_band_pkg::HOLD_MS * CYCLES_PER_MS;
    logic [31:0] hold_cyc_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n || band_select_line.oe != antenna_band_pkg::LINES_ALL
                || band_select_line.out != antenna_band_pkg::CODE_POLL) begin
            hold_cyc_q <= 32'h0;
        end else begin
            hold_cyc_q <= hold_cyc_q + 32'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_release;
        band_select_line.oe == antenna_band_pkg::LINES_NONE ##1
            band_select_line.oe == antenna_band_pkg::LINES_NONE;
    endsequence

    property p_normal_drive;
        state_q == ST_NORMAL |-> band_select_line.oe == antenna_band_pkg::LINES_ALL
            && band_select_line.out == drive_q;
    endproperty
    a_normal_drive: assert property (p_normal_drive) else $error("band lines not driven");

    property p_poll_code;
        state_q == ST_NORMAL && query_start |=> band_select_line.out == antenna_band_pkg::CODE_POLL
            && band_select_line.oe == antenna_band_pkg::LINES_ALL;
    endproperty
    a_poll_code: assert property (p_poll_code) else $error("query did not drive code 0000");

    property p_hold_bounds;
        hold_cyc_q != 32'h0 && $fell(band_select_line.oe[0])
            |-> $past(hold_cyc_q) >= HOLD_MIN_CYC && $past(hold_cyc_q) <= HOLD_MAX_CYC;
    endproperty
    a_hold_bounds: assert property (p_hold_bounds) else $error("poll hold out of range");

    property p_hold_max;
        hold_cyc_q <= HOLD_MAX_CYC;
    endproperty
    a_hold_max: assert property (p_hold_max) else $error("poll held too long");

    property p_release_298;
        band_select_line.out == antenna_band_pkg::CODE_POLL && hold_cyc_q == HOLD_CYC
            |-> s_release;
    endproperty
    a_release_298: assert property (p_release_298) else $error("late line release");

    property p_release_all;
        $fell(band_select_line.oe[0]) |-> band_select_line.oe == antenna_band_pkg::LINES_NONE;
    endproperty
    a_release_all: assert property (p_release_all) else $error("partial line release");

    property p_ack_fail;
        state_q == ST_ACK && state_d == ST_NORMAL |=> id_status.unknown && id_status.done
            ##1 !id_status.done;
    endproperty
    a_ack_fail: assert property (p_ack_fail) else $error("bad acknowledge unreported");

    property p_parse_bad;
        state_q == ST_RECV && parse_q == P_BAD |=> id_status.unknown && !id_status.known;
    endproperty
    a_parse_bad: assert property (p_parse_bad) else $error("bad text not reported");

    property p_restore;
        id_status.done |-> band_select_line.out == antenna_band_pkg::CODE_BAND01
            && band_select_line.oe == antenna_band_pkg::LINES_ALL;
    endproperty
    a_restore: assert property (p_restore) else $error("band 01 not restored");

    property p_legacy;
        state_q == ST_NORMAL && !finish && band_load && legacy_antenna
            && band_sel == 4'h5 |=> drive_q == 4'h3;
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy band not offset");

    property p_older;
        drive_q == 4'h7 |=> older_proc_band == 4'h9;
    endproperty
    a_older: assert property (p_older) else $error("older band not offset");

    property p_timeout;
        state_q == ST_RECV && ms_q == MS_W'(antenna_band_pkg::RX_TIMEOUT_MS) |-> 1'b0;
    endproperty
    a_timeout: assert property (p_timeout) else $error("receive timeout missed");

endmodule // antenna_band_interrogation_ctrl

// ==== bench/antenna_id_model.sv ====
// Behavioural identity module of the antenna, answering band code 0000.
// Assumes the bench resolves the band lines, controller first, then this model's drive, then a pull-up.
`timescale 1ns/1ps
module antenna_id_model #(
    parameter int CPM = 20,
    parameter int BITC = 8
) (
    // Clock and lines
    input wire logic core_clk,
    input wire logic [3:0] line,
    // Fault selection: 0 good, 1 no acknowledge, 2 bad text
    input wire logic [1:0] mode,
    // Drive toward the lines
    output logic [3:0] drv,
    output logic drv_en
);
    string txt;

    task automatic send_byte(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            drv[0] <= f[i];
            repeat (BITC) @(posedge core_clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        drv = 4'hF;
        drv_en = 1'b0;
        forever begin
            @(posedge core_clk);
            if (line === 4'h0) begin
                // A fixed poll latency keeps the run short; any value up to 230 ms is legal.
                repeat (50 * CPM) @(posedge core_clk);
                drv <= (mode == 2'h1) ? 4'h6 : 4'hE;
                drv_en <= 1'b1;
                repeat (366 * CPM) @(posedge core_clk);
                txt = (mode == 2'h2) ? "M 1\015\012" : "M, 1-2\015\012";
                drv[0] <= 1'b1;
                repeat (2 * BITC) @(posedge core_clk);
                for (int i = 0; i < txt.len(); i++) send_byte(txt[i]);
                repeat (732 * CPM) @(posedge core_clk);
                drv_en <= 1'b0;
            end
        end
    end
endmodule // antenna_id_model

// ==== bench/antenna_band_interrogation_ctrl_tb_top.sv ====
// Self-checking bench for the band line controller with an antenna model.
// Assumes short timing parameters: 20 cycles a millisecond, 8 cycles a bit.
`timescale 1ns/1ps
module antenna_band_interrogation_ctrl_tb_top;
    localparam int CPM = 20;
    localparam int BITC = 8;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic band_load = 1'b0;
    logic [3:0] band_sel = 4'h1;
    logic legacy_antenna = 1'b0;
    logic query_start = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [3:0] older_proc_band;
    logic [3:0] drv;
    logic drv_en;
    logic [3:0] line_w;
    antenna_band_pkg::line_drive_t bsl;
    antenna_band_pkg::id_status_t st;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;

    // Released lines take the model's drive while drv_en is set, else the pull-up level.
    assign line_w = (bsl.oe & bsl.out) | (~bsl.oe & (drv_en ? drv : 4'hF));

    antenna_band_interrogation_ctrl #(.CYCLES_PER_MS(CPM), .BIT_CYCLES(BITC)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .band_select_line_in(line_w),
        .band_select_line(bsl), .band_load(band_load), .band_sel(band_sel),
        .legacy_antenna(legacy_antenna), .older_proc_band(older_proc_band),
        .query_start(query_start), .id_status(st));
    antenna_id_model #(.CPM(CPM), .BITC(BITC)) peer (
        .core_clk(core_clk), .line(line_w), .mode(mode), .drv(drv), .drv_en(drv_en));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic load(input logic [3:0] s, input logic leg);
        @(posedge core_clk);
        band_load <= 1'b1;
        band_sel <= s;
        legacy_antenna <= leg;
        @(posedge core_clk);
        band_load <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic t_bands();
        load(4'h5, 1'b0);
        chk("line code", 16'(bsl.out), 16'h5);
        for (int b = 3; b <= 9; b++) begin
            load(4'(b), 1'b1);
            chk("legacy code", 16'(bsl.out), 16'(b - 2));
            @(posedge core_clk);
            #1;
            chk("older band", 16'(older_proc_band), 16'(b));
        end
        chk("drive enable", 16'(bsl.oe), 16'hF);
        load(4'h0, 1'b0);
        chk("poll code refused", 16'(bsl.out), 16'h7);
        load(4'hA, 1'b1);
        chk("legacy range", 16'(bsl.out), 16'h7);
    endtask

    // Waits stay bounded so a stuck controller still reaches the report.
    task automatic t_query(input logic [1:0] m, input logic [15:0] exp);
        @(posedge core_clk);
        mode <= m;
        query_start <= 1'b1;
        @(posedge core_clk);
        query_start <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("poll code", {bsl.out, bsl.oe, 7'h0, st.busy}, 16'h0F01);
        for (n = 1; bsl.oe !== 4'h0 && n < 8000; n++) begin
            @(posedge core_clk);
            #1;
        end
        chk("hold cycles", 16'(n), 16'(298 * CPM));
        for (n = 0; st.done !== 1'b1 && n < 20000; n++) begin
            @(posedge core_clk);
            #1;
        end
        chk("done rise", 16'(st.done), 16'h1);
        chk("status", 16'({st.known, st.unknown, st.band_count}), exp);
        chk("restore", {8'h0, bsl.out, bsl.oe}, 16'h1F);
        @(posedge core_clk);
        #1;
        chk("done pulse", 16'(st.done), 16'h0);
        for (n = 0; drv_en !== 1'b0 && n < 30000; n++) begin
            @(posedge core_clk);
            #1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 100000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk("reset drive", {bsl.out, bsl.oe, st}, 16'h1F00);
        t_bands();
        t_query(2'h0, 16'h21);
        t_query(2'h2, 16'h10);
        t_query(2'h1, 16'h10);
        conclude();
    end
endmodule // antenna_band_interrogation_ctrl_tb_top
